// ==== verilog/dma_control.sv ====
`timescale 1ns/1ps
`include "dma_params.svh"
// What this block does
// - two mode bits select mode 1, 2, 3
// - direction bit one decrements address, else increments
// - busy sets on recognised request, clears last byte
// - block-end flag sets last byte, read clears
// - interrupt only for enabled channel block completion
// - request-enable zero ignores that channel's request
// - fixed priority, channel 0 highest, 3 lowest
// - rotating priority moves serviced channel to last
// - summary flag follows interrupt, cause read clears
// - chaining copies channel 3 registers next cycle
// - chaining only while chain-enable bit set
// - chain-select picks channel 0, 1 or 2
// - channel-count bit zero allows channels 0, 1 only
// - bus request held until byte or block done
// - block-end low one cycle during last byte
// - steal request mode 1, burst request modes 2,3
// - channel code outputs carry serviced channel number
// - 16-bit count decremented as each transfer ends
module dma_control (
  input  wire logic        MCLK,
  input  wire logic        SRST,
  input  wire logic        REG_SEL_N,
  input  wire logic        REG_RNW,
  input  wire logic [4:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  output logic             REG_RDATA_OE,
  input  wire logic [3:0]  TRANSFER_REQUEST,
  input  wire logic        GRANT_IN,
  output logic             STEAL_BUS_REQUEST_N,
  output logic             BURST_BUS_REQUEST_N,
  output logic             TRANSFER_STROBE_N,
  output logic             CHANNEL_CODE_LOW,
  output logic             CHANNEL_CODE_HIGH,
  output logic             CHANNEL_CODE_HIGH_OE,
  output logic             IRQ_BLOCK_END_N,
  output logic      [15:0] ADDR_OUT,
  output logic             ADDR_OE,
  output logic             RW_OUT,
  output logic             RW_OE
);
  dma_pkg::top_state_t q;
  dma_pkg::top_state_t d;
  dma_pkg::mode_t      mode;
  dma_core_if          core ();

  logic       acc;
  logic       rd;
  logic       wr;
  logic       xfer;
  logic       last;
  logic       req_now;
  logic       bus_req;
  logic       chain_hit;
  logic [3:0] sel_mask;
  logic [3:0] mode_ok;
  logic [1:0] chain_sel;
  logic [3:0] allowed;
  logic [3:0] elig;

  // ----------------------------------------
  // sub-blocks
  // ----------------------------------------
  dma_prio_arbiter u_arb (
    .clk (MCLK),
    .rst (SRST),
    .bus (core.arb)
  );

  dma_chan_store u_store (
    .clk (MCLK),
    .rst (SRST),
    .bus (core.store)
  );

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // mode 1 and 2 move one byte per grant, mode 3 the whole block
  function automatic dma_pkg::mode_t mode_of(input logic [3:0] c);
    unique case ({c[`CC_MODE_HIGH], c[`CC_MODE_LOW]})
      2'b10:   mode_of = dma_pkg::MODE_3;
      2'b01:   mode_of = dma_pkg::MODE_1;
      2'b00:   mode_of = dma_pkg::MODE_2;
      default: mode_of = dma_pkg::MODE_BAD;
    endcase
  endfunction

  // ----------------------------------------
  // per-channel eligibility
  // ----------------------------------------
  // each channel is judged on its own: a defined mode, its enable bit,
  // and whether the channel count setting lets it be selected at all;
  // an undefined mode code never asks for service, so a mis-set channel
  // sits quietly instead of guessing a transfer type
  for (genvar g = 0; g < 4; g++) begin : g_chan
    assign mode_ok[g] = (mode_of(q.ctrl[g]) != dma_pkg::MODE_BAD);
    assign allowed[g] = sel_mask[g] & mode_ok[g];
    assign elig[g]    = TRANSFER_REQUEST[g] & q.req_en[g] & allowed[g];
  end

  // register select map:
  //   00-0f  address and count bytes, four per channel, high byte first
  //   10-13  channel control, low nibble written, flags in the top bits
  //   14     priority: rotate flag and request enables
  //   15     interrupt: summary flag and per-channel enables
  //   16     chain: channel count, chain select, chain enable
  //   others read as zero and ignore writes
  // accesses are refused while the outside grant is high, because the
  // select and address pins are then in use by the transfer itself
  // register access only while the processor owns the bus
  assign acc = ~REG_SEL_N & ~GRANT_IN;
  assign rd  = acc & REG_RNW;
  assign wr  = acc & ~REG_RNW;

  assign sel_mask  = q.chain[`DC_FOUR] ? 4'hf : 4'h3;
  assign chain_sel = q.chain[2:1];
  assign mode      = mode_of(q.ctrl[q.ch]);
  assign xfer      = (q.st == dma_pkg::ST_XFER);
  // last byte: the count still holds one while the strobe is out
  assign last      = xfer && (core.cur_cnt == `LAST_COUNT);
  assign req_now   = TRANSFER_REQUEST[q.ch] & q.req_en[q.ch];
  // chaining is decided while the last byte is moving, so the copy
  // cycle follows directly
  assign chain_hit = q.chain[`DC_ENABLE] && (chain_sel != `NO_CHAIN)
                     && (chain_sel == q.ch);

  // ----------------------------------------
  // links to the sub-blocks
  // ----------------------------------------
  // the arbiter sees only eligible requests; the store sees byte writes
  // below the control window and the per-cycle step commands
  assign core.req       = elig;
  assign core.rotate    = q.rotate;
  assign core.served    = xfer && (last || mode != dma_pkg::MODE_3);
  assign core.served_ch = q.ch;
  assign core.wr_en     = wr && !REG_ADDR[4];
  assign core.reg_idx   = REG_ADDR[3:0];
  assign core.wr_data   = REG_WDATA;
  assign core.xfer_en   = xfer;
  assign core.xfer_ch   = q.ch;
  assign core.xfer_down = q.ctrl[q.ch][`CC_DOWN];
  assign core.chain_go  = (q.st == dma_pkg::ST_CHAIN);
  assign core.chain_ch  = chain_sel;

  // ----------------------------------------
  // register file and transfer sequencer
  // ----------------------------------------
  // sequencer walk, one line per state:
  //   idle  - arbiter offers the best eligible channel; busy is raised
  //   req   - bus request pin low, waiting for the outside grant
  //   xfer  - one byte on the bus, strobe low, count and address step
  //   hold  - burst channel paused by a dropped request or grant,
  //           bus request kept low so the grant comes back to it
  //   chain - one spare cycle in which channel 3 is copied over
  // single-byte modes fall back to idle after each byte so that every
  // byte is arbitrated afresh; that costs a cycle per byte but keeps
  // one busy channel from locking the others out
  // the register file shares this process so set and clear of the
  // flags resolve in one place, with the set written last to win
  always_comb begin
    d       = q;
    d.rd_oe = rd;
    // register writes
    if (wr && REG_ADDR[4]) begin
      unique case (REG_ADDR)
        `OFF_PRIO: begin
          d.rotate = REG_WDATA[`PC_ROTATE];
          d.req_en = REG_WDATA[3:0];
        end
        `OFF_IRQ:   d.die   = REG_WDATA[3:0];
        `OFF_CHAIN: d.chain = REG_WDATA[3:0];
        default: begin
          if (REG_ADDR[4:2] == 3'(`OFF_CTRL_BASE >> 2)) begin
            d.ctrl[REG_ADDR[1:0]] = REG_WDATA[3:0];
          end
        end
      endcase
    end
    // reads capture data and clear flags before any set below
    if (rd) begin
      d.rdata = 8'h00;
      if (!REG_ADDR[4]) begin
        d.rdata = core.rd_byte;
      end else begin
        unique case (REG_ADDR)
          `OFF_PRIO:  d.rdata = {q.rotate, 3'h0, q.req_en};
          `OFF_IRQ:   d.rdata = {q.irq, 3'h0, q.die};
          `OFF_CHAIN: d.rdata = {4'h0, q.chain};
          default: begin
            if (REG_ADDR[4:2] == 3'(`OFF_CTRL_BASE >> 2)) begin
              d.rdata = {q.bend[REG_ADDR[1:0]], q.busy[REG_ADDR[1:0]],
                         2'h0, q.ctrl[REG_ADDR[1:0]]};
              d.bend[REG_ADDR[1:0]] = 1'b0;
              if (q.irq && q.irq_ch == REG_ADDR[1:0]) begin
                d.irq = 1'b0;
              end
            end
          end
        endcase
      end
    end
    // sequencer
    unique case (q.st)
      dma_pkg::ST_IDLE: begin
        if (core.grant_valid) begin
          d.ch                  = core.grant_ch;
          d.busy[core.grant_ch] = 1'b1;
          d.st                  = dma_pkg::ST_REQ;
        end
      end
      dma_pkg::ST_REQ: begin
        // the outside arbiter raises grant only once the bus is free
        if (GRANT_IN) begin
          d.st   = dma_pkg::ST_XFER;
          d.aout = core.cur_addr;
          d.rw   = q.ctrl[q.ch][`CC_RW];
        end
      end
      dma_pkg::ST_XFER: begin
        if (last) begin
          d.busy[q.ch] = 1'b0;
          d.bend[q.ch] = 1'b1;
          if (q.die[q.ch]) begin
            d.irq    = 1'b1;
            d.irq_ch = q.ch;
          end
          d.st = chain_hit ? dma_pkg::ST_CHAIN : dma_pkg::ST_IDLE;
        end else if (mode == dma_pkg::MODE_3) begin
          // burst: next address stepped here, store steps in parallel
          d.aout = q.ctrl[q.ch][`CC_DOWN] ? q.aout - `ONE_ADDR
                                          : q.aout + `ONE_ADDR;
          d.st   = (req_now && GRANT_IN) ? dma_pkg::ST_XFER
                                         : dma_pkg::ST_HOLD;
        end else begin
          d.st = dma_pkg::ST_IDLE;
        end
      end
      dma_pkg::ST_HOLD: begin
        if (req_now && GRANT_IN) begin
          d.st   = dma_pkg::ST_XFER;
          d.aout = core.cur_addr;
        end
      end
      dma_pkg::ST_CHAIN: begin
        d.st = dma_pkg::ST_IDLE;
      end
      default: d.st = dma_pkg::ST_IDLE;
    endcase
  end

  // state register, reset clears enables and flags
  // a synchronous clear: no channel can start before software writes
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // pins
  // ----------------------------------------
  // request pins: mode 1 channels use the steal pin, all others the
  // burst pin; decoding from state drops the request in the very cycle
  // in which the byte, or the last byte of a burst, is on the bus
  // request held from recognition until the byte or block finishes
  assign bus_req = (q.st == dma_pkg::ST_REQ) || (q.st == dma_pkg::ST_HOLD)
                   || (xfer && !last && mode == dma_pkg::MODE_3);
  assign STEAL_BUS_REQUEST_N = ~(bus_req && mode == dma_pkg::MODE_1);
  assign BURST_BUS_REQUEST_N = ~(bus_req && mode != dma_pkg::MODE_1);

  // strobe doubles as valid address and acknowledge outside
  assign TRANSFER_STROBE_N    = ~xfer;
  assign CHANNEL_CODE_LOW     = q.ch[0];
  assign CHANNEL_CODE_HIGH    = q.ch[1];
  assign CHANNEL_CODE_HIGH_OE = xfer;

  // shared pin: block end only while strobing, so grant can split it
  // a pending interrupt keeps the pin low through later strobes, so the
  // outside splitter must look at grant, not at the pin alone
  assign IRQ_BLOCK_END_N = ~(q.irq | last);

  // address and direction are driven only while the strobe is out
  assign ADDR_OUT        = q.aout;
  assign ADDR_OE         = xfer;
  assign RW_OUT          = q.rw;
  assign RW_OE           = xfer;

  // read data stands until the next read
  assign REG_RDATA       = q.rdata;
  assign REG_RDATA_OE    = q.rd_oe;
endmodule

// ==== verilog/dma_params.svh ====
`ifndef DMA_PARAMS_SVH
`define DMA_PARAMS_SVH
// ----------------------------------------
// register select offsets
// ----------------------------------------
`define OFF_CTRL_BASE 5'h10
`define OFF_PRIO      5'h14
`define OFF_IRQ       5'h15
`define OFF_CHAIN     5'h16
// ----------------------------------------
// field positions
// ----------------------------------------
`define CC_RW        0
`define CC_MODE_HIGH 1
`define CC_MODE_LOW  2
`define CC_DOWN      3
`define PC_ROTATE    7
`define DC_ENABLE    0
`define DC_FOUR      3
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define ARB_LAST_RST 2'h3
`define LAST_COUNT   16'h0001
`define ONE_ADDR     16'h0001
`define NO_CHAIN     2'h3
`endif

// ==== verilog/dma_pkg.sv ====
package dma_pkg;
  typedef enum logic [1:0] {MODE_2, MODE_1, MODE_3, MODE_BAD} mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_XFER, ST_HOLD, ST_CHAIN} state_t;
  typedef struct packed {
    state_t          st;
    logic [1:0]      ch;
    logic [3:0][3:0] ctrl;
    logic [3:0]      busy;
    logic [3:0]      bend;
    logic            rotate;
    logic [3:0]      req_en;
    logic [3:0]      die;
    logic            irq;
    logic [1:0]      irq_ch;
    logic [3:0]      chain;
    logic [15:0]     aout;
    logic            rw;
    logic [7:0]      rdata;
    logic            rd_oe;
  } top_state_t;
  typedef struct packed {
    logic [1:0] last;
  } arb_state_t;
  typedef struct packed {
    logic [3:0][15:0] addr;
    logic [3:0][15:0] cnt;
  } store_state_t;
endpackage

// ==== verilog/dma_core_if.sv ====
`timescale 1ns/1ps
interface dma_core_if;
  logic [3:0]  req;
  logic        rotate;
  logic        served;
  logic [1:0]  served_ch;
  logic        grant_valid;
  logic [1:0]  grant_ch;
  logic        wr_en;
  logic [3:0]  reg_idx;
  logic [7:0]  wr_data;
  logic [7:0]  rd_byte;
  logic        xfer_en;
  logic [1:0]  xfer_ch;
  logic        xfer_down;
  logic        chain_go;
  logic [1:0]  chain_ch;
  logic [15:0] cur_addr;
  logic [15:0] cur_cnt;
  modport ctl (output req, rotate, served, served_ch, wr_en, reg_idx, wr_data,
               xfer_en, xfer_ch, xfer_down, chain_go, chain_ch,
               input grant_valid, grant_ch, rd_byte, cur_addr, cur_cnt);
  modport arb (input req, rotate, served, served_ch, output grant_valid, grant_ch);
  modport store (input wr_en, reg_idx, wr_data, xfer_en, xfer_ch, xfer_down,
                 chain_go, chain_ch, output rd_byte, cur_addr, cur_cnt);
endinterface

// ==== verilog/dma_prio_arbiter.sv ====
`timescale 1ns/1ps
`include "dma_params.svh"
module dma_prio_arbiter (
  input wire logic clk,
  input wire logic rst,
  dma_core_if.arb  bus
);
  dma_pkg::arb_state_t q;
  dma_pkg::arb_state_t d;
  logic [1:0]          idx;

  // first requesting channel after the last one serviced; in fixed mode, the lowest-numbered requesting channel
  always_comb begin
    d               = q;
    idx             = 2'h0;
    bus.grant_valid = 1'b0;
    bus.grant_ch    = 2'h0;
    for (int i = 0; i < 4; i++) begin
      idx = bus.rotate ? 2'(q.last + 2'(i + 1)) : 2'(i);
      if (!bus.grant_valid && bus.req[idx]) begin
        bus.grant_valid = 1'b1;
        bus.grant_ch    = idx;
      end
    end
    // fixed mode parks the pointer so rotation begins in fixed order
    if (!bus.rotate) begin
      d.last = `ARB_LAST_RST;
    end else if (bus.served) begin
      d.last = bus.served_ch;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{last: `ARB_LAST_RST};
    end else begin
      q <= d;
    end
  end
endmodule

// ==== verilog/dma_chan_store.sv ====
`timescale 1ns/1ps
`include "dma_params.svh"
module dma_chan_store (
  input wire logic clk,
  input wire logic rst,
  dma_core_if.store bus
);
  dma_pkg::store_state_t q;
  dma_pkg::store_state_t d;
  logic [1:0]            wch;

  // byte writes, per-transfer stepping, chain copy
  always_comb begin
    d   = q;
    wch = bus.reg_idx[3:2];
    if (bus.wr_en) begin
      unique case (bus.reg_idx[1:0])
        2'h0: d.addr[wch][15:8] = bus.wr_data;
        2'h1: d.addr[wch][7:0]  = bus.wr_data;
        2'h2: d.cnt[wch][15:8]  = bus.wr_data;
        2'h3: d.cnt[wch][7:0]   = bus.wr_data;
      endcase
    end
    if (bus.xfer_en) begin
      d.cnt[bus.xfer_ch] = q.cnt[bus.xfer_ch] - `LAST_COUNT;
      d.addr[bus.xfer_ch] = bus.xfer_down ? q.addr[bus.xfer_ch] - `ONE_ADDR
                                          : q.addr[bus.xfer_ch] + `ONE_ADDR;
    end
    // chain copy comes a cycle after the last byte, never with a step
    if (bus.chain_go) begin
      d.addr[bus.chain_ch] = q.addr[3];
      d.cnt[bus.chain_ch]  = q.cnt[3];
    end
  end

  // read views
  always_comb begin
    unique case (bus.reg_idx[1:0])
      2'h0: bus.rd_byte = q.addr[bus.reg_idx[3:2]][15:8];
      2'h1: bus.rd_byte = q.addr[bus.reg_idx[3:2]][7:0];
      2'h2: bus.rd_byte = q.cnt[bus.reg_idx[3:2]][15:8];
      2'h3: bus.rd_byte = q.cnt[bus.reg_idx[3:2]][7:0];
    endcase
    bus.cur_addr = q.addr[bus.xfer_ch];
    bus.cur_cnt  = q.cnt[bus.xfer_ch];
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ==== verif/dma_control_props.sv ====
`timescale 1ns/1ps
module dma_control_props (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic REG_SEL_N,
  input wire logic REG_RNW,
  input wire logic GRANT_IN,
  input wire logic REG_RDATA_OE,
  input wire logic STEAL_BUS_REQUEST_N,
  input wire logic BURST_BUS_REQUEST_N,
  input wire logic TRANSFER_STROBE_N,
  input wire logic CHANNEL_CODE_HIGH_OE,
  input wire logic IRQ_BLOCK_END_N,
  input wire logic ADDR_OE,
  input wire logic RW_OE
);
  logic any_req;
  logic rd_take;
  // helper terms, kept out of $past so each takes a plain signal
  assign any_req = !STEAL_BUS_REQUEST_N || !BURST_BUS_REQUEST_N;
  assign rd_take = !REG_SEL_N && REG_RNW && !GRANT_IN;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  // ----
  // bus request and strobe
  // ----
  AST_STEAL_HELD:
  assert property (!STEAL_BUS_REQUEST_N && TRANSFER_STROBE_N |=>
    !STEAL_BUS_REQUEST_N || !TRANSFER_STROBE_N) else $error("steal request dropped early");
  AST_BURST_HELD:
  assert property (!BURST_BUS_REQUEST_N && TRANSFER_STROBE_N |=>
    !BURST_BUS_REQUEST_N || !TRANSFER_STROBE_N) else $error("burst request dropped early");
  AST_ONE_REQUEST:
  assert property (STEAL_BUS_REQUEST_N || BURST_BUS_REQUEST_N) else $error("both requests low");
  AST_STROBE_GRANTED:
  assert property (!TRANSFER_STROBE_N |-> $past(GRANT_IN)) else $error("strobe without grant");
  AST_STROBE_REQUESTED:
  assert property ($fell(TRANSFER_STROBE_N) |-> $past(any_req)) else $error("strobe unrequested");
  AST_DRIVE_IN_STROBE:
  assert property (!TRANSFER_STROBE_N |-> ADDR_OE && RW_OE && CHANNEL_CODE_HIGH_OE)
    else $error("bus not driven in strobe");
  AST_NO_DRIVE_IDLE:
  assert property (ADDR_OE |-> !TRANSFER_STROBE_N) else $error("address driven off strobe");
  AST_RESET_QUIET:
  assert property ($fell(SRST) |-> TRANSFER_STROBE_N && STEAL_BUS_REQUEST_N &&
    BURST_BUS_REQUEST_N && IRQ_BLOCK_END_N) else $error("output active after reset");
  AST_END_AT_STROBE:
  assert property ($fell(IRQ_BLOCK_END_N) |-> !TRANSFER_STROBE_N) else $error("end off strobe");
  // ----
  // register reads
  // ----
  AST_READ_ANSWER:
  assert property (rd_take |=> REG_RDATA_OE) else $error("read not answered");
  AST_READ_ONLY:
  assert property (REG_RDATA_OE |-> $past(rd_take)) else $error("read data without read");
endmodule
bind dma_control dma_control_props dma_control_props_i (
  .MCLK(MCLK),
  .SRST(SRST),
  .REG_SEL_N(REG_SEL_N),
  .REG_RNW(REG_RNW),
  .GRANT_IN(GRANT_IN),
  .REG_RDATA_OE(REG_RDATA_OE),
  .STEAL_BUS_REQUEST_N(STEAL_BUS_REQUEST_N),
  .BURST_BUS_REQUEST_N(BURST_BUS_REQUEST_N),
  .TRANSFER_STROBE_N(TRANSFER_STROBE_N),
  .CHANNEL_CODE_HIGH_OE(CHANNEL_CODE_HIGH_OE),
  .IRQ_BLOCK_END_N(IRQ_BLOCK_END_N),
  .ADDR_OE(ADDR_OE),
  .RW_OE(RW_OE)
);

// ==== verif/dma_bus_partner.sv ====
`timescale 1ns/1ps
module dma_bus_partner (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] raise,
  input  wire logic       refresh,
  input  wire logic       steal_n,
  input  wire logic       burst_n,
  input  wire logic       strobe_n,
  input  wire logic       end_n,
  input  wire logic [1:0] code,
  output logic      [3:0] req_q,
  output logic            grant_q,
  output logic            sys_irq_n,
  output logic            ack_n
);
  // a peripheral holds its request until it sees block end on its channel;
  // refresh takes the bus at random but only between strobes, so the
  // device must wait holding its request; grant follows the request and
  // so clears as the strobe of the byte that ends the request rises
  always @(posedge clk) begin
    if (rst) begin
      req_q <= 4'h0;
      grant_q <= 1'b0;
    end else begin
      req_q <= (req_q | raise) & ~((!strobe_n && !end_n) ? (4'h1 << code) : 4'h0);
      grant_q <= (!steal_n || !burst_n) && (!refresh || !strobe_n);
    end
  end
  assign sys_irq_n = end_n | grant_q;
  // no processor valid-address here, so the system one is the strobe alone
  assign ack_n = strobe_n;
endmodule

// ==== verif/dma_control_test.sv ====
`timescale 1ns/1ps
`include "dma_params.svh"
`define CHK(a, b) begin \
  check_count++; \
  if ((a) !== (b)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); \
  end \
end
module dma_control_test;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        sel_n = 1'b1;
  logic        rnw = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [7:0]  wdata = 8'h00;
  logic [3:0]  raise = 4'h0;
  logic        refresh = 1'b0;
  logic [3:0]  treq;
  logic        grant;
  logic [7:0]  rdata;
  logic        rdata_oe, steal_n, burst_n, stb_n, code_lo, code_hi, irq_n, rw_out;
  logic [15:0] aout;
  logic [7:0]  rq[$];
  logic [18:0] sq[$];
  logic [7:0]  er;
  logic [18:0] es;
  int          miscompares = 0;
  int          check_count = 0;
  initial forever #25 clk = ~clk;
  dma_control dma_control_i (.MCLK(clk), .SRST(srst), .REG_SEL_N(sel_n), .REG_RNW(rnw),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RDATA_OE(rdata_oe),
    .TRANSFER_REQUEST(treq), .GRANT_IN(grant), .STEAL_BUS_REQUEST_N(steal_n),
    .BURST_BUS_REQUEST_N(burst_n), .TRANSFER_STROBE_N(stb_n), .CHANNEL_CODE_LOW(code_lo),
    .CHANNEL_CODE_HIGH(code_hi), .CHANNEL_CODE_HIGH_OE(), .IRQ_BLOCK_END_N(irq_n),
    .ADDR_OUT(aout), .ADDR_OE(), .RW_OUT(rw_out), .RW_OE());
  dma_bus_partner dma_bus_partner_i (.clk(clk), .rst(srst), .raise(raise), .refresh(refresh),
    .steal_n(steal_n), .burst_n(burst_n), .strobe_n(stb_n), .end_n(irq_n),
    .code({code_hi, code_lo}), .req_q(treq), .grant_q(grant), .sys_irq_n(), .ack_n());
  // ----
  // tasks
  // ----
  task automatic close_out();
    $display("checks %0d, miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // registers are only reachable while the partner holds grant low
  task automatic bus(input logic [4:0] a, input logic r, input logic [7:0] d);
    int n;
    @(negedge clk);
    for (n = 0; n < 500 && grant !== 1'b0; n++) @(negedge clk);
    if (n == 500) begin
      miscompares++;
      close_out();
    end
    sel_n <= 1'b0;
    rnw <= r;
    addr <= a;
    wdata <= d;
    @(negedge clk);
    sel_n <= 1'b1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(a, 1'b0, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus(a, 1'b1, 8'h00);
  endtask
  task automatic setch(input int c, input logic [15:0] a, input logic [15:0] n,
                       input logic [7:0] ctl);
    logic [31:0] v;
    int i;
    v = {a, n};
    for (i = 0; i < 4; i++) wr(5'(4 * c + i), v[31 - 8 * i -: 8]);
    wr(5'(`OFF_CTRL_BASE + c), ctl);
  endtask
  task automatic xfer(input int c, input logic w, input logic [15:0] a);
    sq.push_back({w, c[1:0], a});
  endtask
  task automatic go(input logic [3:0] m);
    @(negedge clk);
    raise <= m;
    @(negedge clk);
    raise <= 4'h0;
  endtask
  // settle window also serves as the no-strobe window of refusals
  task automatic drain();
    int n;
    for (n = 0; n < 3000 && sq.size() + rq.size() > 0; n++) @(negedge clk);
    if (n == 3000) begin
      miscompares++;
      close_out();
    end
    repeat (8) @(negedge clk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // ----
  // monitors and random refresh
  // ----
  always @(negedge clk) begin
    refresh <= ($urandom % 6) == 0;
    if (rdata_oe === 1'b1) begin
      `CHK(rq.size() > 0, 1'b1)
      if (rq.size() > 0) er = rq.pop_front();
      `CHK(rdata, er)
    end
    if (stb_n === 1'b0) begin
      `CHK(sq.size() > 0, 1'b1)
      if (sq.size() > 0) es = sq.pop_front();
      `CHK({rw_out, code_hi, code_lo, aout}, es)
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    logic [15:0] a;
    int c;
    int r;
    void'($urandom(66));
    repeat (16) @(negedge clk);
    srst <= 1'b0;
    for (c = 0; c < 8; c++) rd(5'(`OFF_CTRL_BASE + c), 8'h00);
    done("reset");
    a = 16'($urandom);
    wr(`OFF_CHAIN, 8'h08);
    setch(0, a, 16'h0001, 8'h01);
    wr(`OFF_IRQ, 8'h01);
    wr(`OFF_PRIO, 8'h01);
    xfer(0, 1'b1, a);
    go(4'h1);
    drain();
    `CHK(irq_n, 1'b0)
    rd(`OFF_IRQ, 8'h81);
    rd(`OFF_CTRL_BASE, 8'h81);
    rd(`OFF_IRQ, 8'h01);
    rd(`OFF_CTRL_BASE, 8'h01);
    rd(5'h01, a[7:0] + 8'h01);
    drain();
    `CHK(irq_n, 1'b1)
    wr(`OFF_IRQ, 8'h00);
    done("irq");
    for (r = 1; r >= 0; r--) begin
      a = 16'($urandom);
      wr(`OFF_PRIO, {r[0], 7'h03});
      setch(0, a, 16'h0002, 8'h00);
      setch(1, ~a, 16'h0001, 8'h04);
      xfer(0, 1'b0, a);
      if (r == 1) xfer(1, 1'b0, ~a);
      xfer(0, 1'b0, a + 16'h0001);
      if (r == 0) xfer(1, 1'b0, ~a);
      go(4'h3);
      drain();
      done("priority");
    end
    a = 16'($urandom);
    wr(`OFF_PRIO, 8'h04);
    setch(2, a, 16'h0003, 8'h0a);
    for (c = 0; c < 3; c++) xfer(2, 1'b0, a - 16'(c));
    go(4'h4);
    drain();
    rd(5'h0b, 8'h00);
    rd(5'h09, a[7:0] - 8'h03);
    done("burst");
    a = 16'($urandom);
    setch(3, a, 16'h0001, 8'h00);
    wr(`OFF_PRIO, 8'h00);
    go(4'h8);
    drain(); // request ignored while disabled
    wr(`OFF_CHAIN, 8'h00);
    wr(`OFF_PRIO, 8'h08);
    drain(); // channel three hidden in two-channel mode
    xfer(3, 1'b0, a);
    wr(`OFF_CHAIN, 8'h08);
    drain();
    done("refuse");
    a = 16'($urandom);
    setch(3, a, 16'h0005, 8'h00);
    for (c = 0; c < 3; c++) begin
      wr(`OFF_CHAIN, {4'h0, 1'b1, c[1:0], 1'b1});
      wr(`OFF_PRIO, 8'(1 << c));
      setch(c, ~a, 16'h0001, 8'h00);
      xfer(c, 1'b0, ~a);
      go(4'(1 << c));
      drain();
      rd(5'(4 * c + 1), a[7:0]);
      rd(5'(4 * c + 3), 8'h05);
    end
    drain();
    done("chain");
    close_out();
  end
endmodule
